// ==== bsdc_line_ctrl.sv ====
// bisync line controller: register slave, memory request master, serial framer
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module bsdc_line_ctrl #(
  parameter bit EBCDIC_SET = 1'b0           // build option: 0 ASCII, 1 EBCDIC
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // register slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // memory request master
  output logic      [17:0] dma_address_o,
  output logic             dma_read_o,
  output logic             dma_write_o,
  output logic      [15:0] dma_writedata_o,
  input  wire logic [15:0] dma_readdata_i,
  input  wire logic        dma_waitrequest_i,
  // modem line
  input  wire logic        tx_clk_i,
  input  wire logic        rx_clk_i,
  input  wire logic        rx_data_i,
  output logic             tx_data_o,
  // host interrupt
  output logic             irq_o
);

  typedef struct packed {
    logic [2:0]           txc;       // tx clock sync chain and history
    logic [2:0]           rxc;       // rx clock sync chain and history
    logic [1:0]           rxd;       // rx data sync chain
    bsdc_pkg::bsdc_state_t st;
    logic                 rx_mode;
    logic                 build;
    logic                 tst;
    logic [1:0]           ext;
    logic                 ie;
    logic                 rdy;
    logic                 par_err;
    logic                 crc_err;
    logic                 lm_err;
    logic                 dma_err;
    logic                 armed;     // receive buffer granted
    logic [15:0]          bcnt;
    logic [15:0]          badr;
    logic [15:0]          dbuf;
    logic [15:0]          crc;
    logic                 waitreq;
    logic [31:0]          rdata;
    logic [7:0]           tsh;
    logic [2:0]           tbit;
    logic                 txd;
    logic [1:0]           cnt;       // idle, crc and pad counter
    logic [1:0]           tavail;    // fetched bytes not yet sent
    logic                 thi;
    logic                 tprev_dle;
    logic                 transp;
    logic [7:0]           rsh;
    logic [2:0]           rbit;
    logic                 rsyn1;
    logic                 rprev_dle;
    logic                 rhalf;
    logic                 rstarted;
    logic                 dma_rd;
    logic                 dma_wr;
    logic [17:0]          dma_adr;
    logic [15:0]          dma_wd;
    logic                 irq;
  } bsdc_regs_t;

  bsdc_regs_t s;
  bsdc_regs_t n;

  // control character code for the selected set
  function automatic logic [7:0] chr(input logic [2:0] id);
    case (id)
      bsdc_pkg::C_SYN: chr = EBCDIC_SET ? bsdc_pkg::EBC_SYN : bsdc_pkg::ASC_SYN;
      bsdc_pkg::C_DLE: chr = EBCDIC_SET ? bsdc_pkg::EBC_DLE : bsdc_pkg::ASC_DLE;
      bsdc_pkg::C_STX: chr = EBCDIC_SET ? bsdc_pkg::EBC_STX : bsdc_pkg::ASC_STX;
      bsdc_pkg::C_ETX: chr = EBCDIC_SET ? bsdc_pkg::EBC_ETX : bsdc_pkg::ASC_ETX;
      bsdc_pkg::C_ETB: chr = EBCDIC_SET ? bsdc_pkg::EBC_ETB : bsdc_pkg::ASC_ETB;
      bsdc_pkg::C_ENQ: chr = EBCDIC_SET ? bsdc_pkg::EBC_ENQ : bsdc_pkg::ASC_ENQ;
      default:         chr = EBCDIC_SET ? bsdc_pkg::EBC_EOT : bsdc_pkg::ASC_EOT;
    endcase
  endfunction : chr

  // control match; non-transparent ASCII text ignores the parity bit
  function automatic logic is_c(input logic [7:0] c, input logic [2:0] id,
                                input logic tr);
    logic [7:0] k;
    k = chr(id);
    is_c = (EBCDIC_SET || tr) ? (c == k) : (c[6:0] == k[6:0]);
  endfunction : is_c

  // odd parity on non-transparent ASCII text
  function automatic logic [7:0] with_par(input logic [7:0] c, input logic tr);
    with_par = (EBCDIC_SET || tr) ? c : {~^c[6:0], c[6:0]};
  endfunction : with_par

  // one character into the check word, low bit first
  function automatic logic [15:0] crc_upd(input logic [15:0] crc, input logic [7:0] c);
    logic [15:0] r;
    r = crc ^ {8'h00, c};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ bsdc_pkg::CRC_POLY) : (r >> 1);
    end
    crc_upd = r;
  endfunction : crc_upd

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  logic        tx_fall;
  logic        rx_rise;
  logic        acc;
  logic        wr_en;
  logic        go;
  logic [2:0]  idx;
  logic [15:0] ctl_word;
  logic [7:0]  b;
  logic [7:0]  ch;
  logic [7:0]  c;
  logic [1:0]  np;
  logic [7:0]  p0;
  logic [7:0]  p1;
  logic [7:0]  pb;
  logic        wq;
  logic [15:0] wword;
  logic        fin;

  // next-state logic for the whole controller
  always_comb begin
    n       = s;
    tx_fall = s.txc[2] & ~s.txc[1];
    rx_rise = ~s.rxc[2] & s.rxc[1];
    acc     = (avs_read_i | avs_write_i) & s.waitreq;
    wr_en   = avs_write_i & ~s.waitreq;
    go      = 1'b0;
    idx     = avs_address_i[4:2];
    b       = s.thi ? s.dbuf[15:8] : s.dbuf[7:0];
    ch      = bsdc_pkg::PAD_CHAR;
    c       = {s.rxd[1], s.rsh[7:1]};
    np      = 2'd0;
    p0      = c;
    p1      = c;
    pb      = c;
    wq      = 1'b0;
    wword   = s.dbuf;
    fin     = 1'b0;
    ctl_word = {s.par_err | s.crc_err | s.lm_err | s.dma_err, 1'b0, s.dma_err, s.lm_err,
                s.crc_err, s.par_err, 2'b00, s.rdy, s.ie, s.ext, s.tst, s.build,
                s.rx_mode, 1'b0};

    // line input synchronisers
    n.txc = {s.txc[1:0], tx_clk_i};
    n.rxc = {s.rxc[1:0], rx_clk_i};
    n.rxd = {s.rxd[0], rx_data_i};

    // register slave: one wait cycle, answer on the next edge
    n.waitreq = ~acc;
    if (acc) begin
      case (idx)
        bsdc_pkg::REG_CTL:  n.rdata = {16'h0000, ctl_word};
        bsdc_pkg::REG_BCNT: n.rdata = {16'h0000, s.bcnt};
        bsdc_pkg::REG_BADR: n.rdata = {16'h0000, s.badr};
        bsdc_pkg::REG_DBUF: n.rdata = {16'h0000, s.dbuf};
        default:            n.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      case (idx)
        bsdc_pkg::REG_CTL: begin
          if (avs_byteenable_i[0]) begin
            n.rx_mode = avs_writedata_i[bsdc_pkg::CTL_RX];
            n.build   = avs_writedata_i[bsdc_pkg::CTL_BUILD];
            n.tst     = avs_writedata_i[bsdc_pkg::CTL_TST];
            n.ext     = avs_writedata_i[bsdc_pkg::CTL_EXT +: 2];
            n.ie      = avs_writedata_i[bsdc_pkg::CTL_IE];
            go        = avs_writedata_i[bsdc_pkg::CTL_GO];
            if (!avs_writedata_i[bsdc_pkg::CTL_GO]) begin
              n.rdy = 1'b1;
            end
          end
        end
        bsdc_pkg::REG_BCNT: n.bcnt = merge(s.bcnt, avs_writedata_i, avs_byteenable_i);
        bsdc_pkg::REG_BADR: n.badr = merge(s.badr, avs_writedata_i, avs_byteenable_i);
        bsdc_pkg::REG_DBUF: n.dbuf = merge(s.dbuf, avs_writedata_i, avs_byteenable_i);
        default: ;
      endcase
    end

    // launch command: clear done and errors, start or arm
    if (go) begin
      n.rdy     = 1'b0;
      n.par_err = 1'b0;
      n.crc_err = 1'b0;
      n.lm_err  = 1'b0;
      n.dma_err = 1'b0;
      if (n.rx_mode) begin
        n.armed = 1'b1;
      end else if (s.st == bsdc_pkg::S_TX_IDLE) begin
        n.st        = bsdc_pkg::S_TX_SYN;
        n.cnt       = 2'd0;
        n.tbit      = 3'd7;
        n.tavail    = 2'd0;
        n.thi       = 1'b0;
        n.tprev_dle = 1'b0;
        n.transp    = 1'b0;
        n.crc       = bsdc_pkg::CRC_INIT;
      end
    end

    // switch to receive only from transmit idle, back to transmit from any receive state; never both ways at once
    if (s.st == bsdc_pkg::S_TX_IDLE && s.rx_mode) begin
      n.st    = bsdc_pkg::S_RX_HUNT;
      n.rsyn1 = 1'b0;
    end else if ((s.st & (bsdc_pkg::S_RX_HUNT | bsdc_pkg::S_RX_DATA |
                          bsdc_pkg::S_RX_CRC)) != 8'h00 && !s.rx_mode) begin
      n.st    = bsdc_pkg::S_TX_IDLE;
      n.armed = 1'b0;
    end

    // memory request completion
    if ((s.dma_rd | s.dma_wr) && !dma_waitrequest_i) begin
      if (s.dma_rd) begin
        n.dbuf   = dma_readdata_i;
        n.tavail = 2'd2;
        n.thi    = 1'b0;
      end
      n.dma_rd = 1'b0;
      n.dma_wr = 1'b0;
      n.badr   = s.badr + bsdc_pkg::ADR_STEP;
    end

    // transmit prefetch of the next word
    if ((s.st == bsdc_pkg::S_TX_SYN || s.st == bsdc_pkg::S_TX_DATA) && s.tavail == 2'd0
        && !s.dma_rd && !s.dma_wr && s.bcnt != 16'h0000) begin
      n.dma_rd  = 1'b1;
      n.dma_adr = {s.ext, s.badr};
    end

    // transmit serialiser, one bit per falling line clock
    if ((s.st & (bsdc_pkg::S_TX_SYN | bsdc_pkg::S_TX_DATA | bsdc_pkg::S_TX_CRC |
                 bsdc_pkg::S_TX_PAD)) != 8'h00 && tx_fall) begin
      if (s.tbit != 3'd7) begin
        n.tsh  = {1'b1, s.tsh[7:1]};
        n.txd  = s.tsh[1];
        n.tbit = s.tbit + 3'd1;
      end else begin
        n.tbit = 3'd0;
        case (s.st)
          bsdc_pkg::S_TX_SYN: begin
            ch    = chr(bsdc_pkg::C_SYN);
            n.cnt = s.cnt + 2'd1;
            if (s.cnt == bsdc_pkg::SYN_LEAD) begin
              n.st = bsdc_pkg::S_TX_DATA;
            end
          end
          bsdc_pkg::S_TX_DATA: begin
            if (s.transp && s.tprev_dle && s.tavail != 2'd0 &&
                !is_c(b, bsdc_pkg::C_ETX, 1'b1) && !is_c(b, bsdc_pkg::C_ETB, 1'b1)) begin
              ch          = chr(bsdc_pkg::C_DLE);
              n.tprev_dle = 1'b0;
            end else if (s.tavail == 2'd0) begin
              ch        = with_par(chr(bsdc_pkg::C_ENQ), s.transp);
              n.dma_err = 1'b1;
              n.st      = bsdc_pkg::S_TX_PAD;
              n.cnt     = 2'd0;
            end else begin
              ch          = with_par(b, s.transp);
              n.crc       = crc_upd(s.crc, ch);
              n.tavail    = s.tavail - 2'd1;
              n.thi       = 1'b1;
              n.bcnt      = s.bcnt + 16'h0001;
              n.tprev_dle = is_c(b, bsdc_pkg::C_DLE, s.transp);
              if (!s.transp && s.tprev_dle && is_c(b, bsdc_pkg::C_STX, 1'b0)) begin
                n.transp = 1'b1;
              end
              if ((is_c(b, bsdc_pkg::C_ETX, s.transp) || is_c(b, bsdc_pkg::C_ETB, s.transp))
                  && (!s.transp || s.tprev_dle)) begin
                n.st  = bsdc_pkg::S_TX_CRC;
                n.cnt = 2'd0;
              end else if (s.bcnt == bsdc_pkg::BCNT_LAST) begin
                n.st  = bsdc_pkg::S_TX_PAD;
                n.cnt = 2'd0;
              end
            end
          end
          bsdc_pkg::S_TX_CRC: begin
            ch    = (s.cnt == 2'd0) ? s.crc[7:0] : s.crc[15:8];
            n.cnt = s.cnt + 2'd1;
            if (s.cnt == 2'd1) begin
              n.st  = bsdc_pkg::S_TX_PAD;
              n.cnt = 2'd0;
            end
          end
          default: begin
            if (s.cnt == 2'd0) begin
              ch    = bsdc_pkg::PAD_CHAR;
              n.cnt = 2'd1;
            end else begin
              n.st  = bsdc_pkg::S_TX_IDLE;
              n.rdy = 1'b1;
            end
          end
        endcase
        n.tsh = ch;
        n.txd = (n.st == bsdc_pkg::S_TX_IDLE) ? 1'b1 : ch[0];
      end
    end

    // receive deserialiser, one bit per rising line clock
    if ((s.st & (bsdc_pkg::S_RX_HUNT | bsdc_pkg::S_RX_DATA | bsdc_pkg::S_RX_CRC)) != 8'h00
        && rx_rise) begin
      n.rsh  = c;
      n.rbit = s.rbit + 3'd1;
      if (s.st == bsdc_pkg::S_RX_HUNT) begin
        if (!s.rsyn1) begin
          if (is_c(c, bsdc_pkg::C_SYN, 1'b0)) begin
            n.rsyn1 = 1'b1;
            n.rbit  = 3'd0;
          end
        end else if (s.rbit == 3'd7) begin
          n.rsyn1 = 1'b0;
          n.rbit  = 3'd0;
          if (is_c(c, bsdc_pkg::C_SYN, 1'b0)) begin
            n.st        = bsdc_pkg::S_RX_DATA;
            n.rprev_dle = 1'b0;
            n.transp    = 1'b0;
            n.rhalf     = 1'b0;
            n.rstarted  = 1'b0;
            n.crc       = bsdc_pkg::CRC_INIT;
          end
        end
      end else if (s.rbit == 3'd7) begin
        n.rbit = 3'd0;
        if (s.st == bsdc_pkg::S_RX_CRC) begin
          n.crc = crc_upd(s.crc, c);
          n.cnt = s.cnt + 2'd1;
          if (s.cnt == 2'd1) begin
            n.crc_err = (crc_upd(s.crc, c) != 16'h0000);
            fin       = 1'b1;
          end
        end else if (s.transp) begin
          n.rprev_dle = 1'b0;
          if (s.rprev_dle) begin
            if (is_c(c, bsdc_pkg::C_DLE, 1'b1)) begin
              np = 2'd1;
            end else if (!is_c(c, bsdc_pkg::C_SYN, 1'b1)) begin
              np = 2'd2;
              p0 = chr(bsdc_pkg::C_DLE);
              if (is_c(c, bsdc_pkg::C_ETX, 1'b1) || is_c(c, bsdc_pkg::C_ETB, 1'b1)) begin
                n.st  = bsdc_pkg::S_RX_CRC;
                n.cnt = 2'd0;
              end
            end
          end else if (is_c(c, bsdc_pkg::C_DLE, 1'b1)) begin
            n.rprev_dle = 1'b1;
          end else begin
            np = 2'd1;
          end
        end else if (!is_c(c, bsdc_pkg::C_SYN, 1'b0)) begin
          np          = 2'd1;
          n.rprev_dle = is_c(c, bsdc_pkg::C_DLE, 1'b0);
          if (!EBCDIC_SET && !(^c)) begin
            n.par_err = 1'b1;
          end
          if (s.rprev_dle && is_c(c, bsdc_pkg::C_STX, 1'b0)) begin
            n.transp = 1'b1;
          end
          if (is_c(c, bsdc_pkg::C_ETX, 1'b0) || is_c(c, bsdc_pkg::C_ETB, 1'b0)) begin
            n.st  = bsdc_pkg::S_RX_CRC;
            n.cnt = 2'd0;
          end else if (is_c(c, bsdc_pkg::C_ENQ, 1'b0) || is_c(c, bsdc_pkg::C_EOT, 1'b0)) begin
            fin = 1'b1;
          end
        end
      end
    end

    // store up to two characters into the word assembly buffer
    for (int k = 0; k < 2; k++) begin
      if (k < int'(np)) begin
        pb    = (k == 0) ? p0 : p1;
        n.crc = crc_upd(n.crc, pb);
        if (!n.rstarted && !n.armed) begin
          n.dma_err = 1'b1;
        end
        n.rstarted = 1'b1;
        if (!n.armed) begin
          n.rhalf = n.rhalf;
        end else if (n.bcnt == 16'h0000) begin
          n.lm_err = 1'b1;
        end else begin
          n.bcnt = n.bcnt - 16'h0001;
          if (!n.rhalf) begin
            n.dbuf[7:0] = pb;
            n.rhalf     = 1'b1;
          end else begin
            n.dbuf[15:8] = pb;
            n.rhalf      = 1'b0;
            wq           = 1'b1;
            wword        = {pb, n.dbuf[7:0]};
          end
        end
      end
    end

    // end of received message: flush odd byte, done, hunt again
    if (fin) begin
      if (n.rhalf && n.armed) begin
        wq    = 1'b1;
        wword = {8'h00, n.dbuf[7:0]};
      end
      n.rhalf = 1'b0;
      n.rdy   = 1'b1;
      n.armed = 1'b0;
      n.st    = bsdc_pkg::S_RX_HUNT;
      n.rsyn1 = 1'b0;
    end

    // memory write request; a word lost to a busy bus is an error
    if (wq) begin
      if (n.dma_rd || n.dma_wr) begin
        n.dma_err = 1'b1;
      end else begin
        n.dma_wr  = 1'b1;
        n.dma_wd  = wword;
        n.dma_adr = {n.ext, n.badr};
      end
    end

    n.irq = n.ie & n.rdy;
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s         <= '0;
      s.st      <= bsdc_pkg::S_TX_IDLE;
      s.rdy     <= bsdc_pkg::CTL_RESET[bsdc_pkg::CTL_RDY];
      s.bcnt    <= bsdc_pkg::REG_RESET;
      s.badr    <= bsdc_pkg::REG_RESET;
      s.dbuf    <= bsdc_pkg::REG_RESET;
      s.waitreq <= 1'b1;
      s.txd     <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state flops
  assign avs_readdata_o    = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign dma_address_o     = s.dma_adr;
  assign dma_read_o        = s.dma_rd;
  assign dma_write_o       = s.dma_wr;
  assign dma_writedata_o   = s.dma_wd;
  assign tx_data_o         = s.txd;
  assign irq_o             = s.irq;

endmodule : bsdc_line_ctrl

// ==== bsdc_line_ctrl_chk.sv ====
// port assertions for the bisync line controller
`timescale 1ns/1ps
module bsdc_line_ctrl_chk (
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [17:0] dma_address_o,
  input wire logic        dma_read_o,
  input wire logic        dma_write_o,
  input wire logic        dma_waitrequest_i,
  input wire logic        tx_data_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // register handshake, reset state and memory requests
  a_bus_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus wait");
  a_bus_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait pulse");
  a_launch_zero: assert property (!avs_waitrequest_o && avs_read_i
    && avs_address_i[4:2] == 3'h0 |-> !avs_readdata_o[0]) else $error("launch bit");
  a_reset_quiet: assert property (disable iff (1'b0) reset_i
    |=> tx_data_o && !irq_o && !dma_read_o && !dma_write_o) else $error("reset");
  a_half_duplex: assert property (!(dma_read_o && dma_write_o))
    else $error("both ways");
  a_mem_hold: assert property ((dma_read_o || dma_write_o) && dma_waitrequest_i
    |=> (dma_read_o || dma_write_o) && $stable(dma_address_o)) else $error("mem hold");
  a_mem_release: assert property ((dma_read_o || dma_write_o) && !dma_waitrequest_i
    |=> !dma_read_o && !dma_write_o) else $error("mem release");
  a_irq_follows: assert property (!avs_waitrequest_o && avs_read_i
    && avs_address_i[4:2] == 3'h0 |-> $past(irq_o) == (avs_readdata_o[6] && avs_readdata_o[7]))
    else $error("irq level");
  c_mem_rd: cover property (dma_read_o && !dma_waitrequest_i);
  c_mem_wr: cover property (dma_write_o && !dma_waitrequest_i);
  c_irq: cover property ($rose(irq_o));
endmodule : bsdc_line_ctrl_chk

bind bsdc_line_ctrl bsdc_line_ctrl_chk chk_u (.clk_sys_i, .reset_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .dma_address_o,
  .dma_read_o, .dma_write_o, .dma_waitrequest_i, .tx_data_o, .irq_o);

// ==== bsdc_line_ctrl_test.sv ====
// testbench for the bisync line controller
`timescale 1ns/1ps
module bsdc_line_ctrl_test;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [4:0]  avs_address_i = 5'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, r;
  logic        avs_waitrequest_o, dma_read_o, dma_write_o, tx_data_o, irq_o, lclk, rxd;
  logic [17:0] dma_address_o, ma;
  logic [15:0] dma_writedata_o;
  logic        dma_waitrequest_i = 1'b1;
  logic [31:0] wq[$];
  int          n_fail = 0, tests_run = 0, cyc = 0;
  // expected line stream: syncs, text, check word, pad; then receive stream
  logic [7:0]  tx_exp[9] = '{8'h16, 8'h16, 8'h16, 8'h16, 8'h02, 8'h83, 8'h40, 8'hc1, 8'hff};
  logic [7:0]  rx_seq[7] = '{8'h16, 8'h16, 8'h02, 8'h16, 8'h83, 8'h40, 8'hc1};

  always #20 clk_sys_i = ~clk_sys_i;

  bsdc_line_ctrl dut_u (.clk_sys_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'h3), .avs_readdata_o, .avs_waitrequest_o,
    .dma_address_o, .dma_read_o, .dma_write_o, .dma_writedata_o, .dma_readdata_i(16'h0302),
    .dma_waitrequest_i, .tx_clk_i(lclk), .rx_clk_i(lclk), .rx_data_i(rxd), .tx_data_o, .irq_o);
  bsdc_modem_model m_u (.tx_data_i(tx_data_o), .lclk_o(lclk), .rxd_o(rxd));

  // memory slave with one wait cycle; records fetch address and stored words
  always @(posedge clk_sys_i) begin
    dma_waitrequest_i <= !(dma_waitrequest_i && (dma_read_o || dma_write_o));
    if (dma_read_o && !dma_waitrequest_i) ma <= dma_address_o;
    if (dma_write_o && !dma_waitrequest_i) wq.push_back({dma_address_o[15:0], dma_writedata_o});
  end

  // run limit; a hang counts as a mismatch
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic ck(input logic [31:0] s, input logic [31:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : ck

  // one register access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0, d};
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : acc

  task automatic wait_rdy;
    do acc(1'b0, 5'h00, 16'h0); while (r[7] !== 1'b1);
  endtask : wait_rdy

  task automatic summarize;
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // register checks, one transmission, then one reception
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    acc(1'b0, 5'h00, 16'h0);
    ck(r, 32'h0080, "control reset");
    acc(1'b0, 5'h04, 16'h0);
    ck(r, 32'h0, "unmapped");
    acc(1'b1, 5'h08, 16'hfffe);
    acc(1'b1, 5'h10, 16'h0200);
    acc(1'b0, 5'h08, 16'h0);
    ck(r, 32'hfffe, "byte count");
    ck(m_u.q.size(), 32'h0, "line quiet");
    acc(1'b1, 5'h00, 16'h0041);
    acc(1'b0, 5'h00, 16'h0);
    ck(r, 32'h0040, "control launched");
    wait_rdy();
    ck(r, 32'h00c0, "control sent");
    ck(irq_o, 1'b1, "irq");
    ck(ma, 18'h00200, "fetch address");
    foreach (tx_exp[i]) ck(m_u.q[i], tx_exp[i], "tx char");
    acc(1'b1, 5'h00, 16'h0002);
    acc(1'b1, 5'h08, 16'h0004);
    acc(1'b1, 5'h10, 16'h0300);
    acc(1'b1, 5'h00, 16'h0003);
    acc(1'b0, 5'h00, 16'h0);
    ck(r, 32'h0002, "control receive");
    foreach (rx_seq[i]) m_u.send(rx_seq[i]);
    @(negedge lclk);
    m_u.busy = 1'b0;
    wait_rdy();
    ck(r, 32'h0082, "control received");
    ck(wq[0], {16'h0300, 16'h8302}, "stored word");
    summarize();
  end
endmodule : bsdc_line_ctrl_test

// ==== bsdc_modem_model.sv ====
// modem model: line clock, receive sender, transmit capture
`timescale 1ns/1ps
module bsdc_modem_model (
  // line side
  input  wire logic tx_data_i,
  output logic      lclk_o,
  output logic      rxd_o
);
  logic [7:0] sh;
  logic       on = 1'b0;
  logic       busy = 1'b0;
  int         n = 0;
  logic [7:0] q[$];
  initial lclk_o = 1'b0;
  initial rxd_o = 1'b0;
  // free-running 320 ns modem clock
  always #160 lclk_o = ~lclk_o;
  // idle line toggles so a stale level never reads as data
  always @(negedge lclk_o) if (!busy) rxd_o <= ~rxd_o;
  // send one character lsb first after each falling edge
  task automatic send(input logic [7:0] b);
    busy = 1'b1;
    for (int i = 0; i < 8; i++) @(negedge lclk_o) rxd_o <= b[i];
  endtask : send
  // gather transmitted characters from the first space bit on
  always @(posedge lclk_o) begin
    if (on || tx_data_i === 1'b0) begin
      on = 1'b1;
      sh = {tx_data_i, sh[7:1]};
      n = n + 1;
      if (n == 8) begin
        q.push_back(sh);
        n = 0;
      end
    end
  end
endmodule : bsdc_modem_model

// ==== bsdc_pkg.sv ====
// constants, state encoding and register map of the bisync line controller
// How it works
// - reset lands in transmit idle, line quiet
// - transmit starts only on launch command
// - four sync idles precede the message
// - ETX/ETB ending appends two CRC characters
// - exactly one all-ones pad closes transmission
// - transparent data DLEs are sent doubled
// - control DLE before ETX/ETB stays single
// - transmit end sets done, interrupts if enabled
// - two consecutive sync idles give sync
// - first non-sync character after sync is data
// - memory writes only after launch command
// - drop SYN, DLE SYN, first DLE of pair
// - check CRC word, then set done
// - stay receiving and hunting until transmit mode
// - ASCII odd parity on non-transparent text
// - build option picks ASCII or EBCDIC controls
// - half-duplex, data moves by memory requests
// - four registers at fixed offsets from base
// - launch bit 0 write-only, reads zero
// - receive mode bit 1, cleared by reset
// - done bit 7 cleared by launch, set otherwise
package bsdc_pkg;

  // register offsets (word index; byte address is four times this)
  localparam logic [2:0] REG_CTL  = 3'h0;
  localparam logic [2:0] REG_BCNT = 3'h2;
  localparam logic [2:0] REG_BADR = 3'h4;
  localparam logic [2:0] REG_DBUF = 3'h6;

  // control and status register fields
  localparam int CTL_GO    = 0;
  localparam int CTL_RX    = 1;
  localparam int CTL_BUILD = 2;
  localparam int CTL_TST   = 3;
  localparam int CTL_EXT   = 4;
  localparam int CTL_IE    = 6;
  localparam int CTL_RDY   = 7;
  localparam int CTL_CNO   = 8;
  localparam int CTL_NI    = 9;
  localparam int CTL_PAR   = 10;
  localparam int CTL_CRC   = 11;
  localparam int CTL_LM    = 12;
  localparam int CTL_DMA   = 13;
  localparam int CTL_TO    = 14;
  localparam int CTL_ERR   = 15;

  // reset values
  localparam logic [15:0] CTL_RESET = 16'h0080;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // control character identifiers
  localparam logic [2:0] C_SYN = 3'h0;
  localparam logic [2:0] C_DLE = 3'h1;
  localparam logic [2:0] C_STX = 3'h2;
  localparam logic [2:0] C_ETX = 3'h3;
  localparam logic [2:0] C_ETB = 3'h4;
  localparam logic [2:0] C_ENQ = 3'h5;
  localparam logic [2:0] C_EOT = 3'h6;

  // ASCII codes
  localparam logic [7:0] ASC_SYN = 8'h16;
  localparam logic [7:0] ASC_DLE = 8'h10;
  localparam logic [7:0] ASC_STX = 8'h02;
  localparam logic [7:0] ASC_ETX = 8'h03;
  localparam logic [7:0] ASC_ETB = 8'h17;
  localparam logic [7:0] ASC_ENQ = 8'h05;
  localparam logic [7:0] ASC_EOT = 8'h04;
  // EBCDIC codes
  localparam logic [7:0] EBC_SYN = 8'h32;
  localparam logic [7:0] EBC_DLE = 8'h10;
  localparam logic [7:0] EBC_STX = 8'h02;
  localparam logic [7:0] EBC_ETX = 8'h03;
  localparam logic [7:0] EBC_ETB = 8'h26;
  localparam logic [7:0] EBC_ENQ = 8'h2d;
  localparam logic [7:0] EBC_EOT = 8'h37;

  // framing figures
  localparam logic [7:0]  PAD_CHAR  = 8'hff;
  localparam logic [1:0]  SYN_LEAD  = 2'h3;   // index of last of four leading idles
  localparam logic [15:0] CRC_POLY  = 16'ha001; // reflected x16+x15+x2+1
  localparam logic [15:0] CRC_INIT  = 16'h0000;
  localparam logic [15:0] BCNT_LAST = 16'hffff;
  localparam logic [15:0] ADR_STEP  = 16'h0002;

  // controller states
  typedef enum logic [7:0] {
    S_TX_IDLE = 8'h01,
    S_TX_SYN  = 8'h02,
    S_TX_DATA = 8'h04,
    S_TX_CRC  = 8'h08,
    S_TX_PAD  = 8'h10,
    S_RX_HUNT = 8'h20,
    S_RX_DATA = 8'h40,
    S_RX_CRC  = 8'h80
  } bsdc_state_t;

endpackage : bsdc_pkg
